// >>> hw/rsa_top.sv
// Purpose: Applies the device state after a power-on or watchdog reset cause.
// Assumes: Cause inputs are synchronous one-cycle pulses; AXI4-Lite register access.
// Notes: Registers that a reset reloads live here and drive the core and ports.
// Behaviour
// RQ1: Power-on clears timeout and powerdown flags.
// RQ2: Normal-mode watchdog reset sets timeout only.
// RQ3: Idle/sleep watchdog reset sets both flags.
// RQ4: Power-on disables every interrupt source; the code keeps irq_mask_r, so unmasked events still raise irq.
// RQ5: Power-on clears counters; watchdog then runs.
// RQ6: Power-on turns the timer module off.
// RQ7: Power-on makes all port pins inputs.
// RQ8: Power-on points stack pointer at top.
// RQ9: Power-on/normal watchdog reload defaults; idle keeps.
// RQ10: Power-on forces the program counter zero.
// RQ11: Idle watchdog resets only PC and SP.
// RQ12: Simultaneous power-on and watchdog act as power-on.
// RQ13: Watchdog handling uses registered power mode.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module rsa_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Reset causes and power mode.
  input wire logic por_req,
  input wire logic wdt_timeout,
  input wire rsa_pkg::rsa_mode_t power_mode,
  // AXI4-Lite slave.
  input wire logic [rsa_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rsa_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsa_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rsa_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // State applied to the core and peripherals.
  output logic watchdog_timeout_flag,
  output logic powerdown_flag,
  output logic watchdog_run,
  output logic [7:0] watchdog_control_reg,
  output logic [3:0] port_direction_reg,
  output logic [3:0] port_a_latch,
  output logic [7:0] int_enable,
  output logic timer_on,
  output rsa_pkg::rsa_action_t core_action,
  output logic irq
);

  // Low-power decode, also used by the checks below.
  function automatic logic is_low_power(input rsa_pkg::rsa_mode_t m);
    is_low_power = (m == rsa_pkg::RSA_MODE_IDLE) || (m == rsa_pkg::RSA_MODE_SLEEP);
  endfunction

  // True when an address names a mapped register.
  function automatic logic is_mapped(input logic [rsa_pkg::AXI_ADDR_W-1:0] a);
    case (a)
      rsa_pkg::OFS_STATUS, rsa_pkg::OFS_WDOG_CTRL, rsa_pkg::OFS_PORT_DIR,
      rsa_pkg::OFS_PORT_LATCH, rsa_pkg::OFS_INT_EN, rsa_pkg::OFS_TIMER_CTL,
      rsa_pkg::OFS_IRQ_STAT, rsa_pkg::OFS_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  rsa_pkg::rsa_mode_t mode_r; // Power mode as seen last cycle.
  rsa_pkg::rsa_cause_t cause; // Decoded cause of this cycle.
  rsa_pkg::rsa_wr_state_t wr_state_r; // Write channel progress.
  logic [rsa_pkg::AXI_ADDR_W-1:0] awaddr_r; // Captured write address.
  logic [rsa_pkg::AXI_DATA_W-1:0] wdata_r; // Captured write data.
  logic [3:0] wstrb_r; // Captured byte enables.
  logic [rsa_pkg::EVT_W-1:0] irq_stat_r; // Sticky event bits.
  logic [rsa_pkg::EVT_W-1:0] irq_mask_r; // Event enables.
  logic wr_fire; // A complete write lands this cycle.
  logic [rsa_pkg::AXI_ADDR_W-1:0] wr_addr; // Address of the landing write.
  logic [rsa_pkg::AXI_DATA_W-1:0] wr_data; // Data of the landing write.
  logic [3:0] wr_strb; // Byte enables of the landing write.
  logic rd_take; // A read address is taken this cycle.
  logic reload; // Registers return to their defaults.
  logic [rsa_pkg::AXI_DATA_W-1:0] rd_word; // Read mux result.

  // The mode is sampled a cycle early so a mode change racing the time-out
  // cannot glitch the choice of handling.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= rsa_pkg::RSA_MODE_FAST;
    end
    else if (ce)
    begin
      mode_r <= power_mode;
    end
  end

  // Cause decode; power-on masks a coincident time-out.
  always_comb
  begin
    cause.por = por_req; // RQ12
    cause.wdt_normal = wdt_timeout && !por_req && !is_low_power(mode_r); // RQ13
    cause.wdt_idle = wdt_timeout && !por_req && is_low_power(mode_r); // RQ13
  end

  // Default reload happens for power-on and normal watchdog only.
  assign reload = cause.por || cause.wdt_normal; // RQ9

  // Reset flags; software cannot write them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (cause.por)
      begin
        // Both flags read zero after power-on.
        watchdog_timeout_flag <= 1'b0; // RQ1
        powerdown_flag <= 1'b0; // RQ1
      end
      else if (cause.wdt_normal)
      begin
        // Powerdown flag keeps its value.
        watchdog_timeout_flag <= 1'b1; // RQ2
      end
      else if (cause.wdt_idle)
      begin
        watchdog_timeout_flag <= 1'b1; // RQ3
        powerdown_flag <= 1'b1; // RQ3
      end
    end
  end

  // Core actions pulse for one cycle after the cause.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      core_action <= '0;
      watchdog_run <= 1'b0;
    end
    else if (ce)
    begin
      // Every cause restarts the program at address zero.
      core_action.pc_to_zero <= cause.por || cause.wdt_normal || cause.wdt_idle; // RQ10 RQ11
      core_action.sp_to_top <= cause.por || cause.wdt_normal || cause.wdt_idle; // RQ8 RQ11
      core_action.counters_clear <= cause.por; // RQ5
      // The watchdog starts right after power-on and never stops here.
      if (cause.por)
      begin
        watchdog_run <= 1'b1; // RQ5
      end
    end
  end

  // Landing write: captured halves or the ones arriving now.
  always_comb
  begin
    wr_fire = 1'b0;
    wr_addr = awaddr_r;
    wr_data = wdata_r;
    wr_strb = wstrb_r;
    case (wr_state_r)
      rsa_pkg::RSA_WR_IDLE:
      begin
        wr_fire = s_axi_awvalid && s_axi_wvalid;
        wr_addr = s_axi_awaddr;
        wr_data = s_axi_wdata;
        wr_strb = s_axi_wstrb;
      end
      rsa_pkg::RSA_WR_GOT_ADDR:
      begin
        wr_fire = s_axi_wvalid;
        wr_data = s_axi_wdata;
        wr_strb = s_axi_wstrb;
      end
      rsa_pkg::RSA_WR_GOT_DATA:
      begin
        wr_fire = s_axi_awvalid;
        wr_addr = s_axi_awaddr;
      end
      default:
      begin
        wr_fire = 1'b0;
      end
    endcase
  end

  // Software registers; a reset cause beats a write in the same cycle, except at the irq mask.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_control_reg <= rsa_pkg::WDOG_CTRL_DEFAULT;
      port_direction_reg <= rsa_pkg::PORT_DIR_DEFAULT;
      port_a_latch <= rsa_pkg::PORT_LATCH_DEFAULT;
      int_enable <= rsa_pkg::INT_EN_DEFAULT;
      timer_on <= rsa_pkg::TIMER_CTL_DEFAULT;
      irq_mask_r <= rsa_pkg::IRQ_MASK_DEFAULT;
    end
    else if (ce)
    begin
      if (reload)
      begin
        watchdog_control_reg <= rsa_pkg::WDOG_CTRL_DEFAULT; // RQ9
        port_direction_reg <= rsa_pkg::PORT_DIR_DEFAULT; // RQ7
        port_a_latch <= rsa_pkg::PORT_LATCH_DEFAULT; // RQ9
        int_enable <= rsa_pkg::INT_EN_DEFAULT; // RQ4
        timer_on <= rsa_pkg::TIMER_CTL_DEFAULT; // RQ6
      end
      else if (wr_fire && wr_strb[0] && !cause.wdt_idle)
      begin
        // An idle watchdog reset leaves contents alone, so writes are held
        // back only in that cycle to keep the reset atomic.
        case (wr_addr)
          rsa_pkg::OFS_WDOG_CTRL: watchdog_control_reg <= wr_data[7:0];
          rsa_pkg::OFS_PORT_DIR: port_direction_reg <= wr_data[3:0];
          rsa_pkg::OFS_PORT_LATCH: port_a_latch <= wr_data[3:0];
          rsa_pkg::OFS_INT_EN: int_enable <= wr_data[7:0];
          rsa_pkg::OFS_TIMER_CTL: timer_on <= wr_data[0];
          default: ;
        endcase
      end
      // The mask is bus plumbing, not device state, so no cause touches it.
      if (wr_fire && wr_strb[0] && wr_addr == rsa_pkg::OFS_IRQ_MASK)
      begin
        irq_mask_r <= wr_data[rsa_pkg::EVT_W-1:0];
      end
    end
  end

  // Write channel: address and data in either order, then one response.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_state_r <= rsa_pkg::RSA_WR_IDLE;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsa_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (wr_state_r)
        rsa_pkg::RSA_WR_IDLE, rsa_pkg::RSA_WR_GOT_ADDR, rsa_pkg::RSA_WR_GOT_DATA:
        begin
          if (s_axi_awready && s_axi_awvalid)
          begin
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wready && s_axi_wvalid)
          begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (wr_fire)
          begin
            // Unmapped addresses answer with a slave error.
            wr_state_r <= rsa_pkg::RSA_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(wr_addr) ? rsa_pkg::RESP_OKAY : rsa_pkg::RESP_SLVERR;
          end
          else if (s_axi_awready && s_axi_awvalid)
          begin
            wr_state_r <= rsa_pkg::RSA_WR_GOT_ADDR;
          end
          else if (s_axi_wready && s_axi_wvalid)
          begin
            wr_state_r <= rsa_pkg::RSA_WR_GOT_DATA;
          end
        end
        default:
        begin
          // Both readies stay low until the response is taken.
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state_r <= rsa_pkg::RSA_WR_IDLE;
          end
        end
      endcase
    end
  end

  assign rd_take = s_axi_arready && s_axi_arvalid;

  // Read mux; unimplemented bits read as zero.
  always_comb
  begin
    rd_word = '0;
    case (s_axi_araddr)
      rsa_pkg::OFS_STATUS:
      begin
        rd_word[rsa_pkg::STAT_TIMEOUT_BIT] = watchdog_timeout_flag;
        rd_word[rsa_pkg::STAT_POWERDOWN_BIT] = powerdown_flag;
        rd_word[rsa_pkg::STAT_WDOG_RUN_BIT] = watchdog_run;
      end
      rsa_pkg::OFS_WDOG_CTRL: rd_word[7:0] = watchdog_control_reg;
      rsa_pkg::OFS_PORT_DIR: rd_word[3:0] = port_direction_reg;
      rsa_pkg::OFS_PORT_LATCH: rd_word[3:0] = port_a_latch;
      rsa_pkg::OFS_INT_EN: rd_word[7:0] = int_enable;
      rsa_pkg::OFS_TIMER_CTL: rd_word[0] = timer_on;
      rsa_pkg::OFS_IRQ_STAT: rd_word[rsa_pkg::EVT_W-1:0] = irq_stat_r;
      rsa_pkg::OFS_IRQ_MASK: rd_word[rsa_pkg::EVT_W-1:0] = irq_mask_r;
      default: rd_word = '0;
    endcase
  end

  // Read channel: one read in flight, data one cycle after the address.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rsa_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? rsa_pkg::RESP_OKAY : rsa_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Sticky events, cleared by reading them; a new event beats the clear.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      if (rd_take && s_axi_araddr == rsa_pkg::OFS_IRQ_STAT)
      begin
        irq_stat_r <= cause;
      end
      else
      begin
        irq_stat_r <= irq_stat_r | cause;
      end
      // The level lags the sticky bits by one cycle to keep it a flop.
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_POR_FLAGS: assert property (ce && por_req |=> !watchdog_timeout_flag && !powerdown_flag) // RQ1
    else $error("Flags not cleared after power-on.");
  AST_WDT_NORMAL: assert property (ce && cause.wdt_normal |=>
    watchdog_timeout_flag && powerdown_flag == $past(powerdown_flag)) // RQ2
    else $error("Normal watchdog reset flags wrong.");
  AST_WDT_IDLE: assert property (ce && wdt_timeout && !por_req && is_low_power(mode_r) |=>
    watchdog_timeout_flag && powerdown_flag) // RQ3
    else $error("Idle watchdog reset flags wrong.");
  AST_INT_OFF: assert property (ce && por_req |=> int_enable == 8'h00 && !timer_on) // RQ4
    else $error("Interrupts or timer alive after power-on.");
  AST_COUNTERS: assert property (ce && por_req |=> core_action.counters_clear && watchdog_run) // RQ5
    else $error("Counters not cleared after power-on.");
  AST_PORT_IN: assert property (ce && reload |=> port_direction_reg == rsa_pkg::PORT_DIR_DEFAULT
    && port_a_latch == rsa_pkg::PORT_LATCH_DEFAULT
    && watchdog_control_reg == rsa_pkg::WDOG_CTRL_DEFAULT) // RQ7
    else $error("Defaults not loaded.");
  AST_PC_SP: assert property (ce && (por_req || wdt_timeout) |=>
    core_action.pc_to_zero && core_action.sp_to_top) // RQ8
    else $error("PC or SP not reset.");
  AST_IDLE_KEEP: assert property (ce && cause.wdt_idle && !wr_fire |=>
    $stable(port_direction_reg) && $stable(watchdog_control_reg) && !core_action.counters_clear) // RQ11
    else $error("Idle watchdog reset changed registers.");
  AST_COLLIDE: assert property (ce && por_req && wdt_timeout |=> !watchdog_timeout_flag) // RQ12
    else $error("Coincident causes not treated as power-on.");
  AST_MODE_SEL: assert property (ce && wdt_timeout && !por_req && !is_low_power(mode_r)
    && !powerdown_flag |=> !powerdown_flag) // RQ13
    else $error("Normal-mode time-out took idle handling.");

endmodule
`default_nettype wire

// >>> inc/rsa_pkg.sv
// Purpose: Shared constants and types for the reset state applier.
// Assumes: AXI4-Lite with 32-bit data; every register takes one aligned word.
// Notes: Register offsets are byte addresses; defaults are the reset values.
`default_nettype none
package rsa_pkg;
  // Bus geometry.
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_WDOG_CTRL = 8'h04;
  localparam logic [7:0] OFS_PORT_DIR = 8'h08;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h0C;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_TIMER_CTL = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  // Status field positions.
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_POWERDOWN_BIT = 1;
  localparam int STAT_WDOG_RUN_BIT = 2;
  // Interrupt event bit positions, shared by status and mask.
  localparam int EVT_POR_BIT = 0;
  localparam int EVT_WDT_NORMAL_BIT = 1;
  localparam int EVT_WDT_IDLE_BIT = 2;
  localparam int EVT_W = 3;
  // Reset values of the registers that a reset reloads.
  localparam logic [7:0] WDOG_CTRL_DEFAULT = 8'h53;
  localparam logic [3:0] PORT_DIR_DEFAULT = 4'hF;
  localparam logic [3:0] PORT_LATCH_DEFAULT = 4'hF;
  localparam logic [7:0] INT_EN_DEFAULT = 8'h00;
  localparam logic [0:0] TIMER_CTL_DEFAULT = 1'h0;
  localparam logic [EVT_W-1:0] IRQ_MASK_DEFAULT = 3'h0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Power modes reported by the power-mode controller.
  typedef enum logic [1:0] {
    RSA_MODE_FAST = 2'b00,
    RSA_MODE_SLOW = 2'b01,
    RSA_MODE_IDLE = 2'b10,
    RSA_MODE_SLEEP = 2'b11
  } rsa_mode_t;
  // Write channel progress.
  typedef enum logic [1:0] {
    RSA_WR_IDLE = 2'b00,
    RSA_WR_GOT_ADDR = 2'b01,
    RSA_WR_GOT_DATA = 2'b10,
    RSA_WR_RESP = 2'b11
  } rsa_wr_state_t;
  // Decoded reset cause of one cycle; at most one bit is set.
  typedef struct packed {
    logic wdt_idle;
    logic wdt_normal;
    logic por;
  } rsa_cause_t;
  // Core-facing one-cycle actions.
  typedef struct packed {
    logic sp_to_top;
    logic pc_to_zero;
    logic counters_clear;
  } rsa_action_t;
endpackage
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the reset state applier, driven over its own ports.
// Assumes: Clock enable held high except during one power-on pulse; AXI4-Lite outputs are registered, so handshakes sample at edges.
// Notes: Each cause is a one-cycle pulse; expectations come from package defaults and bench values.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Clock, reset and cause inputs.
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic por_req = 1'b0;
  logic wdt_timeout = 1'b0;
  rsa_pkg::rsa_mode_t power_mode = rsa_pkg::RSA_MODE_FAST;
  // Bus master side signals.
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  // Applied state seen at the outputs.
  logic watchdog_timeout_flag;
  logic powerdown_flag;
  logic watchdog_run;
  logic [7:0] watchdog_control_reg;
  logic [3:0] port_direction_reg;
  logic [3:0] port_a_latch;
  logic [7:0] int_enable;
  logic timer_on;
  rsa_pkg::rsa_action_t core_action;
  logic irq;
  // Bench bookkeeping.
  int error_cnt = 0;
  int total_checks = 0;
  logic [1:0] resp;
  logic exp_pd;
  logic [27:0] st;
  // Order of the modes: idle first, so a normal reset later must keep a set powerdown flag.
  rsa_pkg::rsa_mode_t modes [4] = '{rsa_pkg::RSA_MODE_IDLE, rsa_pkg::RSA_MODE_FAST,
    rsa_pkg::RSA_MODE_SLEEP, rsa_pkg::RSA_MODE_SLOW};
  logic [7:0] rst_ofs [8] = '{rsa_pkg::OFS_STATUS, rsa_pkg::OFS_WDOG_CTRL, rsa_pkg::OFS_PORT_DIR,
    rsa_pkg::OFS_PORT_LATCH, rsa_pkg::OFS_INT_EN, rsa_pkg::OFS_TIMER_CTL,
    rsa_pkg::OFS_IRQ_STAT, rsa_pkg::OFS_IRQ_MASK};
  logic [31:0] rst_val [8] = '{32'h0, 32'h53, 32'hF, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0};

  // A half period of 2 ns gives the 250 MHz clock.
  always #2 ref_clk = ~ref_clk;

  // All flags and registers, not core_action or irq, packed in one word so one compare covers them for a whole cause.
  assign st = {watchdog_timeout_flag, powerdown_flag, watchdog_run, watchdog_control_reg,
    port_direction_reg, port_a_latch, int_enable, timer_on};

  rsa_top i_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .por_req(por_req), .wdt_timeout(wdt_timeout),
    .power_mode(power_mode), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag),
    .watchdog_run(watchdog_run), .watchdog_control_reg(watchdog_control_reg),
    .port_direction_reg(port_direction_reg), .port_a_latch(port_a_latch),
    .int_enable(int_enable), .timer_on(timer_on), .core_action(core_action), .irq(irq)
  );

  // Prints the verdict and ends the run; also reached when a wait runs out.
  task automatic final_report;
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Case equality, so an unknown value never counts as a match.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A wait that used up its bound counts as a mismatch and closes the run.
  task automatic hang(input string nm);
    error_cnt++;
    $display("mismatch %s expected handshake seen none", nm);
    final_report();
  endtask

  // Address and data offered together; each dropped when taken; bready held until bvalid.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 100)
      hang("write");
  endtask

  // Read with rready held from the start; data and response taken at the rvalid edge.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100)
      hang("read");
  endtask

  // Loads values that differ from every default, so a reload or a keep is visible.
  task automatic set_nd;
    axi_wr(rsa_pkg::OFS_WDOG_CTRL, 32'h55, 4'hF, resp);
    axi_wr(rsa_pkg::OFS_PORT_DIR, 32'h5, 4'hF, resp);
    axi_wr(rsa_pkg::OFS_PORT_LATCH, 32'hA, 4'hF, resp);
    axi_wr(rsa_pkg::OFS_INT_EN, 32'hC3, 4'hF, resp);
    axi_wr(rsa_pkg::OFS_TIMER_CTL, 32'h1, 4'hF, resp);
  endtask

  // Expected state word: flags, run bit, then either the defaults or the bench values.
  function automatic logic [31:0] exp_st(input logic to, input logic pd, input logic dflt);
    return dflt ? {4'h0, to, pd, 1'b1, 8'h53, 4'hF, 4'hF, 8'h00, 1'b0}
                : {4'h0, to, pd, 1'b1, 8'h55, 4'h5, 4'hA, 8'hC3, 1'b1};
  endfunction

  // One-cycle cause pulse; mode changes at the same edge, so the design must use the older one.
  task automatic cause(input logic p, input logic w, input rsa_pkg::rsa_mode_t m);
    @(posedge ref_clk);
    por_req <= p;
    wdt_timeout <= w;
    power_mode <= m;
    @(posedge ref_clk);
    por_req <= 1'b0;
    wdt_timeout <= 1'b0;
    #1;
  endtask

  // Main sequence.
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    // Reset alone loads defaults but leaves the watchdog stopped.
    chk("state", exp_st(1'b0, 1'b0, 1'b1) & 32'hDFFFFFF, {4'h0, st});
    for (int i = 0; i < 8; i++)
      rd_chk(rst_ofs[i], rst_val[i], rsa_pkg::RESP_OKAY);
    // Unmapped places are refused; a write with no low strobe changes nothing.
    axi_wr(8'h20, 32'hFF, 4'hF, resp);
    chk("bresp", {30'h0, rsa_pkg::RESP_SLVERR}, {30'h0, resp});
    rd_chk(8'h20, 32'h0, rsa_pkg::RESP_SLVERR);
    axi_wr(rsa_pkg::OFS_WDOG_CTRL, 32'h00, 4'hE, resp);
    rd_chk(rsa_pkg::OFS_WDOG_CTRL, 32'h53, rsa_pkg::RESP_OKAY);
    // Power-on event unmasked; all other events stay masked.
    axi_wr(rsa_pkg::OFS_IRQ_MASK, 32'h1, 4'hF, resp);
    set_nd();
    cause(1'b1, 1'b0, rsa_pkg::RSA_MODE_FAST);
    exp_pd = 1'b0;
    chk("state", exp_st(1'b0, 1'b0, 1'b1), {4'h0, st});
    chk("core_action", 32'h7, {29'h0, core_action});
    @(posedge ref_clk);
    #1;
    chk("core_action", 32'h0, {29'h0, core_action});
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk(rsa_pkg::OFS_IRQ_STAT, 32'h1, rsa_pkg::RESP_OKAY);
    // The level drops at the edge that ends the read, so look once it has settled.
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    // Every power mode once; idle and sleep keep registers, fast and slow reload them.
    for (int i = 0; i < 4; i++)
    begin
      power_mode <= modes[i];
      set_nd();
      cause(1'b0, 1'b1, modes[i]);
      if (modes[i][1])
        exp_pd = 1'b1;
      chk("state", exp_st(1'b1, exp_pd, !modes[i][1]), {4'h0, st});
      chk("core_action", 32'h6, {29'h0, core_action});
      rd_chk(rsa_pkg::OFS_IRQ_STAT, modes[i][1] ? 32'h4 : 32'h2, rsa_pkg::RESP_OKAY);
      #1;
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Both causes together act as power-on alone.
    set_nd();
    cause(1'b1, 1'b1, rsa_pkg::RSA_MODE_IDLE);
    chk("state", exp_st(1'b0, 1'b0, 1'b1), {4'h0, st});
    chk("core_action", 32'h7, {29'h0, core_action});
    rd_chk(rsa_pkg::OFS_IRQ_STAT, 32'h1, rsa_pkg::RESP_OKAY);
    // Mode leaves idle at the very edge of the time-out; handling still follows idle.
    set_nd();
    cause(1'b0, 1'b1, rsa_pkg::RSA_MODE_FAST);
    chk("state", exp_st(1'b1, 1'b1, 1'b0), {4'h0, st});
    chk("core_action", 32'h6, {29'h0, core_action});
    // A low clock enable freezes all state, so even a power-on pulse is ignored.
    @(posedge ref_clk);
    ce <= 1'b0;
    cause(1'b1, 1'b0, rsa_pkg::RSA_MODE_FAST);
    chk("state", exp_st(1'b1, 1'b1, 1'b0), {4'h0, st});
    chk("core_action", 32'h0, {29'h0, core_action});
    ce <= 1'b1;
    // Flags are read-only to software.
    axi_wr(rsa_pkg::OFS_STATUS, 32'h0, 4'hF, resp);
    chk("bresp", {30'h0, rsa_pkg::RESP_OKAY}, {30'h0, resp});
    rd_chk(rsa_pkg::OFS_STATUS, 32'h7, rsa_pkg::RESP_OKAY);
    final_report();
  end
endmodule
`default_nettype wire
